// ==== hdl/cfpr_pkg.sv ====
// constants shared by the cpu frequency program register block
package cfpr_pkg;

    // ==========================================================
    // byte offsets of the control bytes
    localparam logic [7:0] CFPR_OFS_RCV_N = 8'h0B;
    localparam logic [7:0] CFPR_OFS_RCV_M = 8'h0C;
    localparam logic [7:0] CFPR_OFS_CPU_N = 8'h0D;
    localparam logic [7:0] CFPR_OFS_CPU_M = 8'h0E;
    localparam logic [7:0] CFPR_OFS_TEST = 8'h0F;
    localparam logic [7:0] CFPR_OFS_RSVD_A = 8'h10;
    localparam logic [7:0] CFPR_OFS_RSVD_B = 8'h11;

    // ==========================================================
    // field positions
    localparam int CFPR_BIT_CHOICE = 7;
    localparam int CFPR_BIT_PROG_EN = 7;
    localparam int CFPR_M_MSB = 6;
    localparam int CFPR_RATIO_MSB = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] CFPR_RST_ZERO = 8'h00;
    localparam logic [1:0] CFPR_RST_TEST = 2'h3;

    // ==========================================================
    // frequency source of the synthesizer core
    typedef enum logic [1:0]
    {
        CFPR_SRC_STRAP = 2'b00,
        CFPR_SRC_PROG = 2'b01,
        CFPR_SRC_RCV_STRAP = 2'b10,
        CFPR_SRC_RCV_PROG = 2'b11
    } cfpr_src_e;

endpackage : cfpr_pkg

// ==== hdl/cfpr_byte_bank.sv ====
// control byte storage with write and read-back decode
`timescale 1ns/100ps
module cfpr_byte_bank
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // byte access
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic lock_i,
    output logic [7:0] rdata_o,
    // stored fields
    output logic [7:0] rcv_n_o,
    output logic [7:0] rcv_m_byte_o,
    output logic [7:0] cpu_n_o,
    output logic [7:0] cpu_m_byte_o,
    output logic [1:0] test_o,
    output logic m_written_o
);
    import cfpr_pkg::*;

    logic [7:0] rcv_n_r;
    logic [7:0] rcv_m_r;
    logic [7:0] cpu_n_r;
    logic [7:0] cpu_m_r;
    logic [1:0] test_r;
    logic m_wr_r;

    // frequency bytes are frozen while recovery mode holds
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rcv_n_r <= CFPR_RST_ZERO;
            rcv_m_r <= CFPR_RST_ZERO;
            cpu_n_r <= CFPR_RST_ZERO;
            cpu_m_r <= CFPR_RST_ZERO;
        end
        else if (wr_i && !lock_i)
        begin
            case (addr_i)
                CFPR_OFS_RCV_N: rcv_n_r <= wdata_i;
                CFPR_OFS_RCV_M: rcv_m_r <= wdata_i;
                CFPR_OFS_CPU_N: cpu_n_r <= wdata_i;
                CFPR_OFS_CPU_M: cpu_m_r <= wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            test_r <= CFPR_RST_TEST;
        else if (wr_i && addr_i == CFPR_OFS_TEST)
            test_r <= wdata_i[1:0];
    end

    // only the m byte starts a load; n alone waits for it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            m_wr_r <= 1'b0;
        else
            m_wr_r <= wr_i && !lock_i && addr_i == CFPR_OFS_CPU_M;
    end

    // reserved bytes and bits read zero, writes discarded
    always_comb
    begin
        case (addr_i)
            CFPR_OFS_RCV_N: rdata_o = rcv_n_r;
            CFPR_OFS_RCV_M: rdata_o = rcv_m_r;
            CFPR_OFS_CPU_N: rdata_o = cpu_n_r;
            CFPR_OFS_CPU_M: rdata_o = cpu_m_r;
            CFPR_OFS_TEST: rdata_o = {6'h00, test_r};
            default: rdata_o = CFPR_RST_ZERO;
        endcase
    end

    assign rcv_n_o = rcv_n_r;
    assign rcv_m_byte_o = rcv_m_r;
    assign cpu_n_o = cpu_n_r;
    assign cpu_m_byte_o = cpu_m_r;
    assign test_o = test_r;
    assign m_written_o = m_wr_r;

endmodule : cfpr_byte_bank

// ==== hdl/cfpr_recovery_ctl.sv ====
// recovery mode latch driven by watchdog time-out
`timescale 1ns/100ps
module cfpr_recovery_ctl
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watchdog side
    input wire logic watchdog_enable_i,
    input wire logic wd_timeout_i,
    // state
    output logic recovery_o,
    output logic enter_o
);
    logic rcv_r;
    logic enter_r;

    // clearing the enable is the only way out; a time-out that
    // lands with the clear is dropped, since locking needs the enable
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rcv_r <= 1'b0;
        else if (wd_timeout_i && watchdog_enable_i)
            rcv_r <= 1'b1;
        else if (!watchdog_enable_i)
            rcv_r <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            enter_r <= 1'b0;
        else
            enter_r <= wd_timeout_i && watchdog_enable_i && !rcv_r;
    end

    assign recovery_o = rcv_r;
    assign enter_o = enter_r;

endmodule : cfpr_recovery_ctl

// ==== hdl/cpu_freq_program_regs.sv ====
// control byte bank selecting the synthesizer cpu frequency source
// ==========================================================
`timescale 1ns/100ps
module cpu_freq_program_regs
    import cfpr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // host byte access
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // ratio selection
    input wire logic [4:0] strap_ratio_code_i,
    input wire logic [4:0] sw_ratio_code_i,
    input wire logic ratio_override_i,
    // watchdog
    input wire logic watchdog_enable_i,
    input wire logic wd_timeout_i,
    output logic wd_start_o,
    output logic sys_reset_req_o,
    // synthesizer core
    output logic [7:0] syn_n_o,
    output logic [6:0] syn_m_o,
    output logic [4:0] syn_ratio_o,
    output cfpr_pkg::cfpr_src_e syn_src_o,
    output logic syn_load_o,
    output logic recovery_o,
    output logic [1:0] test_mode_o
);
    import cfpr_pkg::*;

    // ==========================================================
    // storage and recovery latch
    logic [7:0] bank_rdata;
    logic [7:0] rcv_n;
    logic [7:0] rcv_m_byte;
    logic [7:0] cpu_n;
    logic [7:0] cpu_m_byte;
    logic [1:0] test_bits;
    logic m_written;
    logic rcv_mode;
    logic rcv_enter;

    cfpr_byte_bank u_bank
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_i(wr_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .lock_i(rcv_mode),
        .rdata_o(bank_rdata),
        .rcv_n_o(rcv_n),
        .rcv_m_byte_o(rcv_m_byte),
        .cpu_n_o(cpu_n),
        .cpu_m_byte_o(cpu_m_byte),
        .test_o(test_bits),
        .m_written_o(m_written)
    );

    cfpr_recovery_ctl u_rcv
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .watchdog_enable_i(watchdog_enable_i),
        .wd_timeout_i(wd_timeout_i),
        .recovery_o(rcv_mode),
        .enter_o(rcv_enter)
    );

    // ==========================================================
    // source selection
    logic choice;
    logic prog_en;
    logic [7:0] n_nxt;
    logic [6:0] m_nxt;
    logic [4:0] ratio_nxt;
    cfpr_src_e src_nxt;

    assign choice = rcv_m_byte[CFPR_BIT_CHOICE];
    assign prog_en = cpu_m_byte[CFPR_BIT_PROG_EN];

    always_comb
    begin
        // ratio never follows recovery: override alone picks it
        ratio_nxt = ratio_override_i ? sw_ratio_code_i
                                     : strap_ratio_code_i;
        n_nxt = cpu_n;
        m_nxt = cpu_m_byte[CFPR_M_MSB:0];
        src_nxt = CFPR_SRC_STRAP;
        if (rcv_mode)
        begin
            if (choice)
            begin
                n_nxt = rcv_n;
                m_nxt = rcv_m_byte[CFPR_M_MSB:0];
                src_nxt = CFPR_SRC_RCV_PROG;
            end
            else
            begin
                src_nxt = CFPR_SRC_RCV_STRAP;
            end
        end
        else if (prog_en)
        begin
            src_nxt = CFPR_SRC_PROG;
        end
    end

    // ==========================================================
    // core n, m and source words are updated only at a load so they stay stable; ratio is registered every cycle
    logic load_nxt;
    logic [7:0] n_r;
    logic [6:0] m_r;
    logic [4:0] ratio_r;
    cfpr_src_e src_r;
    logic load_r;

    assign load_nxt = rcv_enter || (m_written && !rcv_mode);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            n_r <= CFPR_RST_ZERO;
            m_r <= 7'h00;
            src_r <= CFPR_SRC_STRAP;
        end
        else if (load_nxt)
        begin
            n_r <= n_nxt;
            m_r <= m_nxt;
            src_r <= src_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ratio_r <= 5'h00;
        else
            ratio_r <= ratio_nxt;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            load_r <= 1'b0;
        else
            load_r <= load_nxt;
    end

    // ==========================================================
    // watchdog start and system reset request
    logic wd_start_r;
    logic sys_rst_r;

    // a programmed change counts as a frequency change
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wd_start_r <= 1'b0;
        else
            wd_start_r <= load_nxt && !rcv_enter && watchdog_enable_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sys_rst_r <= 1'b0;
        else
            sys_rst_r <= rcv_enter;
    end

    // ==========================================================
    // read data is registered to keep outputs on flip-flops
    logic [7:0] rdata_r;
    logic rcv_r;
    logic [1:0] test_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_r <= CFPR_RST_ZERO;
        else if (rd_i)
            rdata_r <= bank_rdata;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rcv_r <= 1'b0;
            test_r <= CFPR_RST_TEST;
        end
        else
        begin
            rcv_r <= rcv_mode;
            test_r <= test_bits;
        end
    end

    assign rdata_o = rdata_r;
    assign syn_n_o = n_r;
    assign syn_m_o = m_r;
    assign syn_ratio_o = ratio_r;
    assign syn_src_o = src_r;
    assign syn_load_o = load_r;
    assign recovery_o = rcv_r;
    assign test_mode_o = test_r;
    assign wd_start_o = wd_start_r;
    assign sys_reset_req_o = sys_rst_r;

endmodule : cpu_freq_program_regs

// ==== verification/cfpr_monitor.sv ====
// port checker for the cpu frequency program register block
`timescale 1ns/100ps
module cfpr_monitor
    import cfpr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // host and control inputs
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [4:0] strap_ratio_code_i,
    input wire logic [4:0] sw_ratio_code_i,
    input wire logic ratio_override_i,
    input wire logic watchdog_enable_i,
    input wire logic wd_timeout_i,
    // core side outputs
    input wire logic sys_reset_req_o,
    input wire logic [7:0] syn_n_o,
    input wire logic [6:0] syn_m_o,
    input wire logic [4:0] syn_ratio_o,
    input cfpr_pkg::cfpr_src_e syn_src_o,
    input wire logic syn_load_o,
    input wire logic recovery_o,
    input wire logic [1:0] test_mode_o
);
    // ==========================================================
    // helpers
    logic [4:0] ratio_want;
    logic [6:0] wd_m;
    logic watchdog_enable;
    assign ratio_want = ratio_override_i ? sw_ratio_code_i : strap_ratio_code_i;
    assign wd_m = wdata_i[6:0];
    assign watchdog_enable = wdata_i[7];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // a timeout one cycle earlier would already have locked the bank
    sequence s_m_wr;
        wr_i && addr_i == CFPR_OFS_CPU_M && !recovery_o && !wd_timeout_i
        && !$past(wd_timeout_i) ##1 !wd_timeout_i;
    endsequence
    // ==========================================================
    // properties
    property p_m_load;
        s_m_wr |-> ##1 syn_load_o && syn_m_o == $past(wd_m, 2)
        && syn_src_o == ($past(watchdog_enable, 2) ? CFPR_SRC_PROG : CFPR_SRC_STRAP);
    endproperty
    a_m_load: assert property (p_m_load)
        else $error("m write did not load the programmed words");
    property p_n_no_load;
        (!wr_i ##1 wr_i && addr_i == CFPR_OFS_CPU_N && !wd_timeout_i
        ##1 !wr_i && !wd_timeout_i) |-> ##1 !syn_load_o;
    endproperty
    a_n_no_load: assert property (p_n_no_load)
        else $error("n write alone started a load");
    property p_stable;
        !syn_load_o |-> $stable(syn_n_o) && $stable(syn_m_o)
        && $stable(syn_src_o);
    endproperty
    a_stable: assert property (p_stable)
        else $error("core words moved without a load");
    property p_ratio;
        $past(rst_n_i) |-> syn_ratio_o == $past(ratio_want);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ratio code does not follow override");
    property p_timeout;
        wd_timeout_i && watchdog_enable_i && !recovery_o
        && !$past(wd_timeout_i) |-> ##2 sys_reset_req_o && syn_load_o
        && recovery_o && syn_src_o[1];
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout did not enter recovery");
    property p_timeout_off;
        wd_timeout_i && !watchdog_enable_i |-> ##2 !sys_reset_req_o;
    endproperty
    a_timeout_off: assert property (p_timeout_off)
        else $error("timeout acted while watchdog disabled");
    property p_locked;
        recovery_o && watchdog_enable_i && $past(watchdog_enable_i)
        && $past(watchdog_enable_i, 2) && wr_i && !wd_timeout_i
        && addr_i == CFPR_OFS_CPU_M |-> ##2 !syn_load_o;
    endproperty
    a_locked: assert property (p_locked)
        else $error("frequency write accepted in recovery");
    property p_test_ones;
        test_mode_o == CFPR_RST_TEST;
    endproperty
    a_test_ones: assert property (p_test_ones)
        else $error("vendor test bits left ones");
endmodule : cfpr_monitor

bind cpu_freq_program_regs cfpr_monitor u_mon (.clk_i, .rst_n_i, .wr_i,
    .addr_i, .wdata_i, .strap_ratio_code_i, .sw_ratio_code_i,
    .ratio_override_i, .watchdog_enable_i, .wd_timeout_i, .sys_reset_req_o,
    .syn_n_o, .syn_m_o, .syn_ratio_o, .syn_src_o, .syn_load_o, .recovery_o,
    .test_mode_o);

// ==== verification/cfpr_host_model.sv ====
// behavioural host issuing byte writes and reads to the register block
`timescale 1ns/100ps
module cfpr_host_model
    import cfpr_pkg::*;
(
    // clock
    input wire logic clk_i,
    // byte access
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    initial
    begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'hA5;
        wdata_o = 8'h5A;
    end
    // idle bus shows the inverse so stale values never look valid
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= 1'b1;
        addr_o <= a;
        wdata_o <= (a == CFPR_OFS_TEST) ? (d | 8'h03) : d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : wr_byte
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask : rd_byte
endmodule : cfpr_host_model

// ==== verification/tb_top.sv ====
// self-checking bench for the cpu frequency program register block
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %0t %h %h", $time, g, e); end end
module tb_top
    import cfpr_pkg::*;
;
    logic clk_i, rst_n_i, wr, rd, ovr, wden, wdto, wds, srst, load, rcv;
    logic [7:0] addr, wdata, rdata, syn_n, d;
    logic [6:0] syn_m;
    logic [4:0] strap, sw, ratio;
    logic [1:0] tmode;
    cfpr_src_e src;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int mdl [11:17];
    cpu_freq_program_regs dut (.clk_i, .rst_n_i, .wr_i(wr), .rd_i(rd),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .strap_ratio_code_i(strap), .sw_ratio_code_i(sw),
        .ratio_override_i(ovr), .watchdog_enable_i(wden),
        .wd_timeout_i(wdto), .wd_start_o(wds), .sys_reset_req_o(srst),
        .syn_n_o(syn_n), .syn_m_o(syn_m), .syn_ratio_o(ratio),
        .syn_src_o(src), .syn_load_o(load), .recovery_o(rcv),
        .test_mode_o(tmode));
    cfpr_host_model host (.clk_i, .wr_o(wr), .rd_o(rd), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata));
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    // the request edge has passed when a host task returns; the
    // registered answer stands after the next edge, so look once there
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask : settle
    task automatic chk_syn(input int n, input int m, input int s);
        `CHK(syn_n, 8'(n))
        `CHK(syn_m, 7'(m))
        `CHK(src, cfpr_src_e'(2'(s)))
    endtask : chk_syn
    initial
    begin
        int r;
        {rst_n_i, ovr, wden, wdto, strap, sw} = '0;
        r = $urandom(32'hB327);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int a = 11; a <= 17; a++)
        begin
            host.rd_byte(8'(a), d);
            `CHK(d, (a == 15) ? 8'h03 : 8'h00)
            mdl[a] = $urandom & 255;
            host.wr_byte(8'(a), 8'(mdl[a]));
            mdl[a] = (a < 15) ? mdl[a] : ((a == 15) ? 3 : 0);
        end
        for (int a = 11; a <= 17; a++)
        begin
            host.rd_byte(8'(a), d);
            `CHK(d, 8'(mdl[a]))
        end
        chk_syn(mdl[13], mdl[14] & 127, mdl[14] >> 7);
        for (int e = 0; e < 2; e++)
        begin
            r = $urandom & 255;
            host.wr_byte(CFPR_OFS_CPU_N, 8'(r));
            settle();
            `CHK(load, 1'b0)
            `CHK(syn_n, 8'(mdl[13]))
            mdl[13] = r;
            mdl[14] = (e << 7) | ($urandom & 127);
            wden <= e[0];
            host.wr_byte(CFPR_OFS_CPU_M, 8'(mdl[14]));
            settle();
            `CHK(load, 1'b1)
            `CHK(wds, e[0])
            chk_syn(mdl[13], mdl[14] & 127, e);
        end
        repeat (8)
        begin
            @(posedge clk_i);
            strap <= 5'($urandom);
            sw <= 5'($urandom);
            ovr <= 1'($urandom);
            settle();
            `CHK(ratio, ovr ? sw : strap)
        end
        for (int c = 0; c < 2; c++)
        begin
            mdl[11] = $urandom & 255;
            mdl[12] = (c << 7) | ($urandom & 127);
            host.wr_byte(CFPR_OFS_RCV_N, 8'(mdl[11]));
            host.wr_byte(CFPR_OFS_RCV_M, 8'(mdl[12]));
            @(posedge clk_i);
            wden <= 1'b1;
            wdto <= 1'b1;
            @(posedge clk_i);
            wdto <= 1'b0;
            settle();
            `CHK(srst, 1'b1)
            `CHK({rcv, load}, 2'b11)
            if (c == 1)
                chk_syn(mdl[11], mdl[12] & 127, 3);
            else
                chk_syn(mdl[13], mdl[14] & 127, 2);
            host.wr_byte(CFPR_OFS_CPU_M, 8'($urandom));
            settle();
            `CHK(load, 1'b0)
            @(posedge clk_i);
            wden <= 1'b0;
            wdto <= 1'b1;
            @(posedge clk_i);
            wdto <= 1'b0;
            settle();
            `CHK({rcv, srst}, 2'b00)
        end
        end_sim();
    end
endmodule : tb_top
